// >>> logic/csel_top.sv
// Command source selector of the motor drive with its APB register file.
// Assumes terminal and link inputs are synchronous to ref_clk_i.
module csel_top
  import csel_pkg::*;
#(
  parameter int FREQ_W = 16
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              term_forward_start_i,
  input  wire logic              term_reverse_start_i,
  input  wire logic              term_stop_i,
  input  wire logic              term_jog_i,
  input  wire logic              term_second_function_select_i,
  input  wire logic [MS_W-1:0]   term_multi_speed_selects_i,
  input  wire logic              term_current_input_select_i,
  input  wire logic              term_fault_reset_input_i,
  input  wire logic              term_output_stop_input_i,
  input  wire logic              term_thermal_relay_input_i,
  input  wire logic              term_extra_function_i,
  input  wire logic [FREQ_W-1:0] term_freq2_i,
  input  wire logic [FREQ_W-1:0] term_freq4_i,
  input  wire logic [FREQ_W-1:0] term_freq1_i,
  input  wire logic [CMD_W-1:0]  link_cmd_i,
  input  wire logic [FREQ_W-1:0] link_freq_i,
  input  wire logic              link_freq_wr_i,
  input  wire logic              link_sel_wr_i,
  input  wire logic              link_run_sel_i,
  input  wire logic              link_speed_sel_i,
  input  wire logic              link_drive_reset_i,
  output logic                   forward_start_o,
  output logic                   reverse_start_o,
  output logic                   stop_o,
  output logic                   jog_o,
  output logic                   second_function_select_o,
  output logic      [MS_W-1:0]   multi_speed_selects_o,
  output logic                   current_input_select_o,
  output logic                   fault_reset_input_o,
  output logic                   output_stop_input_o,
  output logic                   thermal_relay_input_o,
  output logic                   extra_function_o,
  output logic      [FREQ_W-1:0] freq2_o,
  output logic      [FREQ_W-1:0] freq4_o,
  output logic      [FREQ_W-1:0] freq1_o,
  output logic                   drive_reset_o
);

  if (FREQ_W < 1 || FREQ_W > 16) begin : g_width_check
    $error("FREQ_W must lie between 1 and 16.");
  end

  logic              link_mode;
  logic              run_command_source_selector;
  logic              speed_command_source_selector;
  logic [COMP_W-1:0] multi_speed_compensation_setting;
  logic [FREQ_W-1:0] link_freq_hold;

  // APB decode.
  wire                setup_phase = psel & ~penable;
  wire                write_now   = psel & penable & pready & pwrite;
  wire [ADDR_W-1:0]   reg_addr    = paddr[ADDR_W-1:0];
  wire                addr_hi_ok  = (paddr[31:ADDR_W] == '0);
  wire                hit_ctrl    = addr_hi_ok & (reg_addr == OFF_CTRL);
  wire                hit_status  = addr_hi_ok & (reg_addr == OFF_STATUS);
  wire                hit_freq    = addr_hi_ok & (reg_addr == OFF_FREQ);
  wire                addr_ok     = hit_ctrl | hit_status | hit_freq;
  wire                ctrl_wr     = write_now & hit_ctrl;

  // Source selection for each function group.
  wire                run_from_link   = link_mode & ~run_command_source_selector;
  wire                speed_from_link = link_mode & ~speed_command_source_selector;
  wire                aux_on          = (multi_speed_compensation_setting == COMP_AUX_ON);
  wire csel_src_e     aux_src         = aux_on ? CSEL_SRC_EXT : CSEL_SRC_NONE;

  wire csel_src_e src_run    = csel_pick(link_mode, run_command_source_selector,
                                         CSEL_SRC_LINK, CSEL_SRC_EXT);
  wire csel_src_e src_stopjog = csel_pick(link_mode, run_command_source_selector,
                                          CSEL_SRC_NONE, CSEL_SRC_EXT);
  wire csel_src_e src_speed  = csel_pick(link_mode, speed_command_source_selector,
                                         CSEL_SRC_LINK, CSEL_SRC_EXT);
  wire csel_src_e src_freq4  = csel_pick(link_mode, speed_command_source_selector,
                                         CSEL_SRC_NONE, CSEL_SRC_EXT);
  wire csel_src_e src_freq1  = csel_pick(link_mode, speed_command_source_selector,
                                         aux_src, CSEL_SRC_EXT);
  wire csel_src_e src_cursel = csel_pick(link_mode, speed_command_source_selector,
                                         CSEL_SRC_NONE, CSEL_SRC_EITHER);
  wire csel_src_e src_fault  = csel_pick(link_mode, 1'b0,
                                         CSEL_SRC_EITHER, CSEL_SRC_EITHER);
  wire csel_src_e src_ostop  = csel_pick(link_mode, run_command_source_selector,
                                         CSEL_SRC_EITHER, CSEL_SRC_EXT);
  wire csel_src_e src_term   = CSEL_SRC_EXT;

  // Link side of each function.
  wire                link_cur_sel = link_cmd_i[CMD_CUR_SEL_BIT];
  wire                link_fault   = link_cmd_i[CMD_FAULT_RST_BIT];
  wire                link_ostop   = link_cmd_i[CMD_OUT_STOP_BIT];
  wire [MS_W-1:0]     link_ms      = link_cmd_i[CMD_MS_LSB +: MS_W];
  wire [FREQ_W-1:0]   zero_freq    = '0;

  // Read data and status.
  wire [31:0] ctrl_word = {24'h00_0000, multi_speed_compensation_setting, 1'b0,
                           speed_command_source_selector, run_command_source_selector,
                           link_mode};
  wire [31:0] status_word = {16'h0000, drive_reset_o, extra_function_o,
                             thermal_relay_input_o, output_stop_input_o,
                             fault_reset_input_o, current_input_select_o,
                             multi_speed_selects_o, second_function_select_o, jog_o,
                             stop_o, reverse_start_o, forward_start_o,
                             run_from_link, speed_from_link};
  wire [31:0] freq_word  = {{(32 - FREQ_W){1'b0}}, link_freq_hold};
  wire [31:0] read_mux   = hit_ctrl   ? ctrl_word   :
                           hit_status ? status_word :
                           hit_freq   ? freq_word   : 32'h0000_0000;

  // A write from the parameter unit takes effect at the APB access edge. A
  // link write in the same cycle wins, being the newer command at the drive.
  wire next_run_sel   = link_sel_wr_i ? link_run_sel_i :
                        ctrl_wr ? pwdata[CTRL_RUN_BIT] : run_command_source_selector;
  wire next_speed_sel = link_sel_wr_i ? link_speed_sel_i :
                        ctrl_wr ? pwdata[CTRL_SPEED_BIT] : speed_command_source_selector;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      link_mode                        <= CTRL_RESET[CTRL_LINK_BIT];
      run_command_source_selector      <= CTRL_RESET[CTRL_RUN_BIT];
      speed_command_source_selector    <= CTRL_RESET[CTRL_SPEED_BIT];
      multi_speed_compensation_setting <= CTRL_RESET[CTRL_COMP_LSB +: COMP_W];
    end else begin
      run_command_source_selector   <= next_run_sel;
      speed_command_source_selector <= next_speed_sel;
      if (ctrl_wr) begin
        link_mode                        <= pwdata[CTRL_LINK_BIT];
        multi_speed_compensation_setting <= pwdata[CTRL_COMP_LSB +: COMP_W];
      end
    end
  end

  // One wait-free access cycle: pready rises in the access phase.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~addr_ok;
      prdata  <= setup_phase ? read_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      drive_reset_o <= 1'b0;
    end else begin
      drive_reset_o <= link_drive_reset_i;
    end
  end

  csel_freq_hold #(.W(FREQ_W)) u_freq_hold (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr_i      (link_freq_wr_i),
    .en_i      (speed_from_link),
    .data_i    (link_freq_i),
    .hold_o    (link_freq_hold)
  );

  csel_route #(.W(1)) u_fwd (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .src_i (src_run),
    .term_i (term_forward_start_i), .link_i (link_cmd_i[CMD_FWD_BIT]),
    .out_o (forward_start_o)
  );
  csel_route #(.W(1)) u_rev (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .src_i (src_run),
    .term_i (term_reverse_start_i), .link_i (link_cmd_i[CMD_REV_BIT]),
    .out_o (reverse_start_o)
  );
  csel_route #(.W(1)) u_second (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .src_i (src_run),
    .term_i (term_second_function_select_i), .link_i (link_cmd_i[CMD_SECOND_BIT]),
    .out_o (second_function_select_o)
  );
  // Stop and jog have no link bit; the link side is held low.
  csel_route #(.W(2)) u_stopjog (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .src_i (src_stopjog),
    .term_i ({term_jog_i, term_stop_i}), .link_i (2'b00),
    .out_o ({jog_o, stop_o})
  );
  csel_route #(.W(MS_W)) u_ms (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .src_i (src_speed),
    .term_i (term_multi_speed_selects_i), .link_i (link_ms),
    .out_o (multi_speed_selects_o)
  );
  csel_route #(.W(FREQ_W)) u_freq2 (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .src_i (src_speed),
    .term_i (term_freq2_i), .link_i (link_freq_hold),
    .out_o (freq2_o)
  );
  csel_route #(.W(FREQ_W)) u_freq4 (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .src_i (src_freq4),
    .term_i (term_freq4_i), .link_i (zero_freq),
    .out_o (freq4_o)
  );
  csel_route #(.W(FREQ_W)) u_freq1 (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .src_i (src_freq1),
    .term_i (term_freq1_i), .link_i (zero_freq),
    .out_o (freq1_o)
  );
  csel_route #(.W(1)) u_cursel (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .src_i (src_cursel),
    .term_i (term_current_input_select_i), .link_i (link_cur_sel),
    .out_o (current_input_select_o)
  );
  csel_route #(.W(1)) u_fault (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .src_i (src_fault),
    .term_i (term_fault_reset_input_i), .link_i (link_fault),
    .out_o (fault_reset_input_o)
  );
  csel_route #(.W(1)) u_ostop (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .src_i (src_ostop),
    .term_i (term_output_stop_input_i), .link_i (link_ostop),
    .out_o (output_stop_input_o)
  );
  // Safety inputs never come from the link, in any mode.
  csel_route #(.W(2)) u_safety (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .src_i (src_term),
    .term_i ({term_extra_function_i, term_thermal_relay_input_i}), .link_i (2'b00),
    .out_o ({extra_function_o, thermal_relay_input_o})
  );

endmodule

// >>> include/csel_pkg.sv
// Package of the command source selector: register map, field layout,
// link command bit positions and the source codes.
// Assumes a 32-bit APB slave with byte addresses in the low eight bits.
package csel_pkg;

  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FREQ   = 8'h08;

  localparam int CTRL_LINK_BIT  = 0;
  localparam int CTRL_RUN_BIT   = 1;
  localparam int CTRL_SPEED_BIT = 2;
  localparam int CTRL_COMP_LSB  = 4;
  localparam int COMP_W         = 4;

  localparam logic [31:0]       CTRL_RESET  = 32'h0000_0000;
  localparam logic [COMP_W-1:0] COMP_AUX_ON = 4'h1;

  localparam int CMD_W            = 16;
  localparam int CMD_CUR_SEL_BIT  = 0;
  localparam int CMD_FWD_BIT      = 1;
  localparam int CMD_REV_BIT      = 2;
  localparam int CMD_SECOND_BIT   = 3;
  localparam int CMD_MS_LSB       = 4;
  localparam int MS_W             = 3;
  localparam int CMD_OUT_STOP_BIT = 7;
  localparam int CMD_FAULT_RST_BIT = 8;

  typedef enum logic [3:0] {
    CSEL_SRC_NONE   = 4'h1,
    CSEL_SRC_EXT    = 4'h2,
    CSEL_SRC_LINK   = 4'h4,
    CSEL_SRC_EITHER = 4'h8
  } csel_src_e;

  // External mode forces the terminals; link mode picks by selector value.
  function automatic csel_src_e csel_pick(input logic      link_mode,
                                          input logic      sel,
                                          input csel_src_e when0,
                                          input csel_src_e when1);
    if (!link_mode) begin
      return CSEL_SRC_EXT;
    end
    return sel ? when1 : when0;
  endfunction

endpackage

// >>> logic/csel_route.sv
// One routed control function: picks terminal, link, both or neither.
// Assumes the source code is stable for the cycle it is sampled in.
module csel_route
  import csel_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire csel_src_e    src_i,
  input  wire logic [W-1:0] term_i,
  input  wire logic [W-1:0] link_i,
  output logic      [W-1:0] out_o
);

  if (W < 1) begin : g_width_check
    $error("W must be at least 1.");
  end

  logic [W-1:0] next_out;

  // The output is registered, so a function whose source did not change
  // sees no glitch when another selector moves.
  always_comb begin
    case (src_i)
      CSEL_SRC_EXT:    next_out = term_i;
      CSEL_SRC_LINK:   next_out = link_i;
      CSEL_SRC_EITHER: next_out = term_i | link_i;
      CSEL_SRC_NONE:   next_out = '0;
      default:         next_out = '0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      out_o <= '0;
    end else begin
      out_o <= next_out;
    end
  end

endmodule

// >>> logic/csel_freq_hold.sv
// Holds the running frequency last written over the controller link while en_i was high.
// Assumes the write strobe is a one-cycle pulse.
module csel_freq_hold
  import csel_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic         wr_i,
  input  wire logic         en_i,
  input  wire logic [W-1:0] data_i,
  output logic      [W-1:0] hold_o
);

  if (W < 1) begin : g_width_check
    $error("W must be at least 1.");
  end

  wire take_write = wr_i & en_i;

  // A write while the speed source is elsewhere is dropped, not deferred.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hold_o <= '0;
    end else if (take_write) begin
      hold_o <= data_i;
    end
  end

endmodule

// >>> dv/csel_assertions.sv
// Concurrent checks on routing, link frequency, drive reset and APB answer of csel_top.
// Assumes it is bound into csel_top and sees its ports by name.
module csel_assertions
  import csel_pkg::*;
#(parameter int FREQ_W = 16) (
  input wire logic              ref_clk_i,
  input wire logic              rst_i,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              term_forward_start_i,
  input wire logic [MS_W-1:0]   term_multi_speed_selects_i,
  input wire logic              term_current_input_select_i,
  input wire logic              term_fault_reset_input_i,
  input wire logic              term_output_stop_input_i,
  input wire logic [FREQ_W-1:0] term_freq1_i,
  input wire logic [CMD_W-1:0]  link_cmd_i,
  input wire logic [FREQ_W-1:0] link_freq_i,
  input wire logic              link_freq_wr_i,
  input wire logic              link_sel_wr_i,
  input wire logic              link_run_sel_i,
  input wire logic              link_speed_sel_i,
  input wire logic              link_drive_reset_i,
  input wire logic              forward_start_o,
  input wire logic [MS_W-1:0]   multi_speed_selects_o,
  input wire logic              current_input_select_o,
  input wire logic              fault_reset_input_o,
  input wire logic              output_stop_input_o,
  input wire logic [FREQ_W-1:0] freq1_o,
  input wire logic [FREQ_W-1:0] freq2_o,
  input wire logic              drive_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadow of the selector state, rebuilt from port traffic alone.
  logic              live, lm, run, spd;
  logic [COMP_W-1:0] comp;
  logic [FREQ_W-1:0] hold;
  wire               ctrl_wr = psel && penable && pready && pwrite && paddr == 32'(OFF_CTRL);
  always_ff @(posedge ref_clk_i) begin
    live <= !rst_i;
    if (rst_i) begin
      {lm, run, spd, comp, hold} <= '0;
    end else begin
      if (ctrl_wr) begin
        {comp, spd, run, lm} <= {pwdata[CTRL_COMP_LSB +: COMP_W], pwdata[CTRL_SPEED_BIT],
                                 pwdata[CTRL_RUN_BIT], pwdata[CTRL_LINK_BIT]};
      end
      // The link wins a same-cycle clash, so its update is placed last.
      if (link_sel_wr_i) begin
        {run, spd} <= {link_run_sel_i, link_speed_sel_i};
      end
      if (link_freq_wr_i && lm && !spd) begin
        hold <= link_freq_i;
      end
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence apb_setup; psel && !penable; endsequence
  sequence apb_answer; pready ##1 !pready; endsequence
  chk_apb_one_wait: assert property (apb_setup |=> apb_answer)
    else $error("apb access not answered in the next cycle");
  chk_ext_terminal: assert property (live && !$past(lm) |->
    forward_start_o == $past(term_forward_start_i) && fault_reset_input_o ==
    $past(term_fault_reset_input_i)) else $error("external mode not from terminals");
  chk_run_terminal: assert property (live && $past(lm && run) |->
    forward_start_o == $past(term_forward_start_i) && output_stop_input_o ==
    $past(term_output_stop_input_i)) else $error("run commands not from terminals");
  chk_run_link: assert property (live && $past(lm && !run) |->
    forward_start_o == $past(link_cmd_i[CMD_FWD_BIT]) && output_stop_input_o ==
    $past(term_output_stop_input_i || link_cmd_i[CMD_OUT_STOP_BIT]))
    else $error("run commands not from link");
  chk_speed_terminal: assert property (live && $past(lm && spd) |->
    multi_speed_selects_o == $past(term_multi_speed_selects_i) && current_input_select_o ==
    $past(term_current_input_select_i || link_cmd_i[CMD_CUR_SEL_BIT]))
    else $error("speed inputs not from terminals");
  chk_speed_link: assert property (live && $past(lm && !spd) |->
    multi_speed_selects_o == $past(link_cmd_i[CMD_MS_LSB +: MS_W]) && !current_input_select_o)
    else $error("speed inputs not from link");
  chk_aux_input: assert property (live && $past(lm && !spd) |-> freq1_o ==
    ($past(comp) == COMP_AUX_ON ? $past(term_freq1_i) : '0)) else $error("aux input wrong");
  chk_fault_either: assert property (live && $past(lm) |-> fault_reset_input_o ==
    $past(term_fault_reset_input_i || link_cmd_i[CMD_FAULT_RST_BIT])) else $error("fault reset");
  chk_link_freq: assert property (live && $past(lm && !spd) |-> freq2_o == $past(hold))
    else $error("link frequency not applied");
  chk_drive_reset: assert property (live |-> drive_reset_o == $past(link_drive_reset_i))
    else $error("drive reset not one cycle behind");
endmodule

// >>> dv/csel_link_model.sv
// Programmable controller model driving the controller link of csel_top.
// Assumes callers leave one rising edge between two of its tasks.
module csel_link_model
  import csel_pkg::*;
(
  input  wire logic             ref_clk_i,
  output logic      [CMD_W-1:0] link_cmd_o = '0,
  output logic      [15:0]      link_freq_o = '0,
  output logic                  link_freq_wr_o = 1'b0,
  output logic                  link_sel_wr_o = 1'b0,
  output logic                  link_run_sel_o = 1'b0,
  output logic                  link_speed_sel_o = 1'b0,
  output logic                  link_drive_reset_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic send_cmd(input logic [CMD_W-1:0] c);
    @(posedge ref_clk_i);
    link_cmd_o <= c;
  endtask
  // Released data is inverted so a stale value can never pass for a fresh one.
  task automatic write_freq(input logic [15:0] f);
    @(posedge ref_clk_i);
    link_freq_o <= f;
    link_freq_wr_o <= 1'b1;
    @(posedge ref_clk_i);
    link_freq_o <= ~f;
    link_freq_wr_o <= 1'b0;
  endtask
  task automatic write_sel(input logic r, input logic s);
    @(posedge ref_clk_i);
    {link_sel_wr_o, link_run_sel_o, link_speed_sel_o} <= {1'b1, r, s};
    @(posedge ref_clk_i);
    {link_sel_wr_o, link_run_sel_o, link_speed_sel_o} <= {1'b0, ~r, ~s};
  endtask
  task automatic reset_drive();
    @(posedge ref_clk_i);
    link_drive_reset_o <= 1'b1;
    @(posedge ref_clk_i);
    link_drive_reset_o <= 1'b0;
  endtask
endmodule

// >>> dv/command_source_selector_bench.sv
// Self-checking bench of csel_top: APB tasks plus the controller link model.
// Assumes one wait-free APB access cycle and one-cycle routing latency.
module command_source_selector_bench
  import csel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, term_forward_start_i, term_reverse_start_i, term_stop_i, term_jog_i;
  logic term_second_function_select_i, term_current_input_select_i, term_fault_reset_input_i;
  logic term_output_stop_input_i, term_thermal_relay_input_i, term_extra_function_i;
  logic [MS_W-1:0] term_multi_speed_selects_i, multi_speed_selects_o;
  logic [15:0] term_freq2_i = 16'h2222, term_freq4_i = 16'h4444, term_freq1_i = 16'h1111;
  logic [15:0] link_freq_i, freq2_o, freq4_o, freq1_o;
  logic [CMD_W-1:0] link_cmd_i;
  logic link_freq_wr_i, link_sel_wr_i, link_run_sel_i, link_speed_sel_i, link_drive_reset_i;
  logic forward_start_o, reverse_start_o, stop_o, jog_o, second_function_select_o;
  logic current_input_select_o, fault_reset_input_o, output_stop_input_o;
  logic thermal_relay_input_o, extra_function_o, drive_reset_o;
  int fail_count = 0, comparisons = 0;
  wire [12:0] vec = {thermal_relay_input_o, extra_function_o, reverse_start_o,
                     second_function_select_o, forward_start_o, stop_o, jog_o,
                     multi_speed_selects_o, current_input_select_o, output_stop_input_o,
                     fault_reset_input_o};
  csel_top csel_top_i (.*);
  csel_link_model csel_link_model_i (.ref_clk_i, .link_cmd_o(link_cmd_i),
    .link_freq_o(link_freq_i), .link_freq_wr_o(link_freq_wr_i), .link_sel_wr_o(link_sel_wr_i),
    .link_run_sel_o(link_run_sel_i), .link_speed_sel_o(link_speed_sel_i),
    .link_drive_reset_o(link_drive_reset_i));
  always #5 ref_clk_i = ~ref_clk_i;
  task automatic report_and_stop();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk_i);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic set_terms(input logic v);
    {term_forward_start_i, term_reverse_start_i, term_stop_i, term_jog_i,
     term_second_function_select_i, term_current_input_select_i, term_fault_reset_input_i,
     term_output_stop_input_i, term_thermal_relay_input_i, term_extra_function_i} <= {10{v}};
    term_multi_speed_selects_i <= {MS_W{v}};
  endtask
  // Routing latency is one cycle, so three edges leave ample margin.
  task automatic settle();
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask
  // Terminals drive ones and the link zeros in one phase, the reverse in the other.
  function automatic logic [12:0] want(input logic r, input logic s, input logic lnk);
    return lnk ? {2'b00, {3{!r}}, 2'b00, {3{!s}}, s, !r, 1'b1}
               : {2'b11, {5{r}}, {3{s}}, s, 2'b11};
  endfunction
  initial begin
    set_terms(1'b0);
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    apb(1'b0, 32'(OFF_CTRL), '0);
    check("ctrl reset", CTRL_RESET, rd);
    apb(1'b0, 32'h0000_0100, '0);
    check("unmapped error", 32'h0000_0001, {31'h0, er});
    check("unmapped data", '0, rd);
    csel_link_model_i.send_cmd('1);
    set_terms(1'b1);
    settle();
    check("external ones", 32'h0000_1FFF, vec);
    set_terms(1'b0);
    settle();
    check("external zeros", '0, vec);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 32'(OFF_CTRL), {24'h00_0000, 4'(i), 1'b0, i[1], i[0], 1'b1});
      csel_link_model_i.send_cmd('0);
      set_terms(1'b1);
      settle();
      check("terminal route", want(i[0], i[1], 1'b0), vec);
      check("aux input", (i[1] || i == 1) ? term_freq1_i : '0, freq1_o);
      check("terminal 4 input", i[1] ? term_freq4_i : '0, freq4_o);
      csel_link_model_i.send_cmd('1);
      set_terms(1'b0);
      settle();
      check("link route", want(i[0], i[1], 1'b1), vec);
    end
    csel_link_model_i.write_sel(1'b0, 1'b0);
    settle();
    check("link selectors", want(1'b0, 1'b0, 1'b1), vec);
    apb(1'b0, 32'(OFF_CTRL), '0);
    check("ctrl after link", 32'h0000_0031, rd);
    apb(1'b0, 32'(OFF_STATUS), '0);
    check("status word", 32'h0000_1BCF, rd);
    csel_link_model_i.write_freq(16'h1234);
    settle();
    check("link frequency", 32'h0000_1234, freq2_o);
    apb(1'b1, 32'(OFF_CTRL), 32'h0000_0035);
    csel_link_model_i.write_freq(16'h0BAD);
    apb(1'b0, 32'(OFF_FREQ), '0);
    check("frequency held", 32'h0000_1234, rd);
    check("terminal frequency", term_freq2_i, freq2_o);
    csel_link_model_i.reset_drive();
    #1;
    check("drive reset", 32'h0000_0001, drive_reset_o);
    report_and_stop();
  end
endmodule
bind csel_top csel_assertions #(.FREQ_W(FREQ_W)) csel_assertions_i (.*);
